// ==== logic/fsu_key_cmp.sv ====
/*
  One key word comparator: supplied word against stored word.
  Assumes both words are stable on the bus clock.
*/
`timescale 1ns/1ps
module fsu_key_cmp #(
  parameter int W = 16
) (
  // Words
  input wire logic [W-1:0] supplied,
  input wire logic [W-1:0] stored,
  // Result
  output logic match
);
  // Exact compare, one word per instance
  assign match = (supplied == stored);
endmodule

// ==== logic/fsu_pkg.sv ====
/*
  Constants for the flash security unlock block: register offsets, status
  bit positions, command codes, field values and command run times.
  Assumes a single 250 MHz bus clock and the plain register port of the
  top module.
*/
package fsu_pkg;
  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [2:0] OFS_STATUS = 3'h0;
  localparam logic [2:0] OFS_INDEX = 3'h1;
  localparam logic [2:0] OFS_PARAM = 3'h2;
  localparam logic [2:0] OFS_SECURITY = 3'h3;
  localparam logic [2:0] OFS_MARGIN = 3'h4;
  // ****************************************************
  // Status bit positions
  // ****************************************************
  localparam int BIT_CMD_COMPLETE_FLAG = 7;
  localparam int BIT_ACCESS_ERROR_FLAG = 5;
  localparam int BIT_PROTECTION_VIOLATION_FLAG = 4;
  localparam int BIT_VERR = 1;
  localparam int BIT_VUNC = 0;
  // ****************************************************
  // Commands, indices and field values
  // ****************************************************
  localparam logic [7:0] CMD_ERASE_VERIFY_ALL = 8'h01;
  localparam logic [7:0] CMD_VERIFY_KEY = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [2:0] IDX_EVA_LAST = 3'h0;
  localparam logic [2:0] IDX_MARGIN_LAST = 3'h1;
  localparam logic [2:0] IDX_KEY_LAST = 3'h4;
  localparam logic [1:0] KEY_ENABLE_FIELD_ON = 2'h2;
  localparam logic [1:0] SEC_OPEN = 2'h2;
  localparam int NUM_KEYS = 4;
  localparam int NUM_PARAMS = 5;
  // ****************************************************
  // Command run times in bus cycles
  // ****************************************************
  localparam logic [16:0] KEY_CYCLES = 17'h001E1;    // 481
  localparam logic [16:0] MARGIN_CYCLES = 17'h0018F; // 399
  localparam int EVA_CYCLES_DEF = 35345;
endpackage

// ==== logic/fsu_sync.sv ====
/*
  Three-flop input synchroniser with agreement filter.
  Assumes the input comes from outside the bus clock domain.
*/
`timescale 1ns/1ps
module fsu_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // A change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= '0;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule

// ==== logic/fsu_top.sv ====
/*
  Flash security unlock sequencer: command launch, key verification with
  lockout, user margin level and erase-verify-all unsecure path.
  Assumes the stored security byte and keys are presented by the flash
  configuration field, and the blank results come from the array.
*/
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module fsu_top #(
  parameter int ERASE_VERIFY_CYCLES = fsu_pkg::EVA_CYCLES_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Stored configuration field
  input wire logic [7:0] STORED_SEC_BYTE,
  input wire logic [15:0] KEY_WORD0,
  input wire logic [15:0] KEY_WORD1,
  input wire logic [15:0] KEY_WORD2,
  input wire logic [15:0] KEY_WORD3,
  // Array blank results, pflash and data memory
  input wire logic PFLASH_BLANK,
  input wire logic DMEM_BLANK,
  // Security outputs
  output logic SECURED,
  output logic DEBUG_ALL_EN,
  output logic [1:0] MARGIN_BLOCK,
  output logic [15:0] MARGIN_LEVEL
);
  typedef enum {FSU_IDLE, FSU_BUSY} fsu_state_t;

  fsu_state_t state;
  logic [16:0] count;
  logic [7:0] run_cmd;
  logic cmd_complete_flag;
  logic access_error_flag;
  logic protection_violation_flag;
  logic verify_error_status;
  logic verify_uncorrectable_status;
  logic [2:0] param_index_ptr;
  logic [15:0] cmd_param_words [fsu_pkg::NUM_PARAMS];
  logic [1:0] security_state_field;
  logic [1:0] key_enable_field;
  logic cfg_loaded;
  logic lockout;
  logic [15:0] stored_key [fsu_pkg::NUM_KEYS];
  logic [fsu_pkg::NUM_KEYS-1:0] key_match;
  logic all_match;
  logic [1:0] blank;
  logic launch;
  logic [7:0] code;
  logic early_err;
  logic finish;
  logic [16:0] eva_cycles;
  logic [16:0] key_age;

  assign eva_cycles = 17'(ERASE_VERIFY_CYCLES);

  // ****************************************************
  // Key comparison and blank input crossing
  // ****************************************************
  assign stored_key[0] = KEY_WORD0;
  assign stored_key[1] = KEY_WORD1;
  assign stored_key[2] = KEY_WORD2;
  assign stored_key[3] = KEY_WORD3;

  // Key n against parameter word n+1, key 0 against the lowest stored word
  generate
    for (genvar k = 0; k < fsu_pkg::NUM_KEYS; k++) begin : g_cmp
      fsu_key_cmp #(.W(16)) u_cmp (
        .supplied(cmd_param_words[k+1]),
        .stored(stored_key[k]),
        .match(key_match[k])
      );
    end
  endgenerate
  assign all_match = &key_match;

  // Blank results settle on an array timebase, so cross them
  fsu_sync #(.W(2)) u_sync (
    .clk(CLK),
    .rst(RST),
    .din({PFLASH_BLANK, DMEM_BLANK}),
    .dout(blank)
  );

  // ****************************************************
  // Command launch decode
  // ****************************************************
  // Launch is a one written to the complete flag while idle and error-free
  assign launch = WR && (ADDR == fsu_pkg::OFS_STATUS) && WDATA[fsu_pkg::BIT_CMD_COMPLETE_FLAG]
                  && cmd_complete_flag && !access_error_flag
                  && !protection_violation_flag && cfg_loaded;
  assign code = cmd_param_words[0][15:8];

  // Launch-time checks that end a command without running it
  always_comb begin
    early_err = 1'b1;
    case (code)
      fsu_pkg::CMD_VERIFY_KEY: begin
        early_err = (param_index_ptr != fsu_pkg::IDX_KEY_LAST)
                    || (key_enable_field != fsu_pkg::KEY_ENABLE_FIELD_ON)
                    || lockout;
      end
      fsu_pkg::CMD_USER_MARGIN: early_err = (param_index_ptr != fsu_pkg::IDX_MARGIN_LAST);
      fsu_pkg::CMD_ERASE_VERIFY_ALL: early_err = (param_index_ptr != fsu_pkg::IDX_EVA_LAST);
      default: early_err = 1'b1;
    endcase
  end

  assign finish = (state == FSU_BUSY) && (count == 17'h00001);

  // ****************************************************
  // Sequencer
  // ****************************************************
  // Runs a command for its documented number of bus cycles
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= FSU_IDLE;
      count <= 17'h00000;
      run_cmd <= 8'h00;
    end else begin
      case (state)
        FSU_IDLE: begin
          if (launch && !early_err) begin
            state <= FSU_BUSY;
            run_cmd <= code;
            if (code == fsu_pkg::CMD_VERIFY_KEY) begin
              count <= fsu_pkg::KEY_CYCLES;
            end else if (code == fsu_pkg::CMD_USER_MARGIN) begin
              count <= fsu_pkg::MARGIN_CYCLES;
            end else begin
              count <= eva_cycles;
            end
          end
        end
        FSU_BUSY: begin
          count <= count - 17'h00001;
          if (finish) begin
            state <= FSU_IDLE;
          end
        end
        default: state <= FSU_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Status flags
  // ****************************************************
  // Complete flag drops on an accepted launch and returns when the command ends
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_complete_flag <= 1'b1;
    end else if (launch) begin
      cmd_complete_flag <= early_err;
    end else if (finish) begin
      cmd_complete_flag <= 1'b1;
    end
  end

  // Error flags: access error set wins over a write-one clear in the same cycle; protection violation is only ever cleared here
  always_ff @(posedge CLK) begin
    if (RST) begin
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      if ((launch && early_err)
          || (finish && run_cmd == fsu_pkg::CMD_VERIFY_KEY && !all_match)) begin
        access_error_flag <= 1'b1;
      end else if (WR && ADDR == fsu_pkg::OFS_STATUS && WDATA[fsu_pkg::BIT_ACCESS_ERROR_FLAG]) begin
        access_error_flag <= 1'b0;
      end
      if (WR && ADDR == fsu_pkg::OFS_STATUS && WDATA[fsu_pkg::BIT_PROTECTION_VIOLATION_FLAG]) begin
        protection_violation_flag <= 1'b0;
      end
    end
  end

  // Verify results belong to the last command; cleared at each launch
  always_ff @(posedge CLK) begin
    if (RST || launch) begin
      verify_error_status <= 1'b0;
      verify_uncorrectable_status <= 1'b0;
    end else if (finish && run_cmd == fsu_pkg::CMD_ERASE_VERIFY_ALL) begin
      verify_error_status <= ~&blank;
    end
  end

  // ****************************************************
  // Parameter words and index pointer
  // ****************************************************
  // Writes land at the word that the index pointer selects; frozen while busy
  always_ff @(posedge CLK) begin
    if (RST) begin
      param_index_ptr <= 3'h0;
      for (int i = 0; i < fsu_pkg::NUM_PARAMS; i++) begin
        cmd_param_words[i] <= 16'h0000;
      end
    end else if (state == FSU_IDLE && cmd_complete_flag) begin
      if (WR && ADDR == fsu_pkg::OFS_INDEX) begin
        param_index_ptr <= WDATA[2:0];
      end
      if (WR && ADDR == fsu_pkg::OFS_PARAM
          && param_index_ptr < 3'(fsu_pkg::NUM_PARAMS)) begin
        cmd_param_words[param_index_ptr] <= WDATA;
      end
    end
  end

  // ****************************************************
  // Security state and lockout
  // ****************************************************
  // Stored byte is sampled once after reset release; it is never written here
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_loaded <= 1'b0;
      key_enable_field <= 2'h0;
      security_state_field <= 2'h0;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      key_enable_field <= STORED_SEC_BYTE[7:6];
      security_state_field <= STORED_SEC_BYTE[1:0];
    end else if (finish && run_cmd == fsu_pkg::CMD_VERIFY_KEY && all_match) begin
      security_state_field <= fsu_pkg::SEC_OPEN;
    end else if (finish && run_cmd == fsu_pkg::CMD_ERASE_VERIFY_ALL && &blank) begin
      security_state_field <= fsu_pkg::SEC_OPEN;
    end
  end

  // A failed key attempt locks out until reset only
  always_ff @(posedge CLK) begin
    if (RST) begin
      lockout <= 1'b0;
    end else if (finish && run_cmd == fsu_pkg::CMD_VERIFY_KEY && !all_match) begin
      lockout <= 1'b1;
    end
  end

  // Margin level for later reads of the selected block
  always_ff @(posedge CLK) begin
    if (RST) begin
      MARGIN_BLOCK <= 2'h0;
      MARGIN_LEVEL <= 16'h0000;
    end else if (finish && run_cmd == fsu_pkg::CMD_USER_MARGIN) begin
      MARGIN_BLOCK <= cmd_param_words[0][1:0];
      MARGIN_LEVEL <= cmd_param_words[1];
    end
  end

  assign SECURED = cfg_loaded && (security_state_field != fsu_pkg::SEC_OPEN);
  assign DEBUG_ALL_EN = !SECURED;

  // ****************************************************
  // Read port
  // ****************************************************
  // Unmapped offsets read zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        fsu_pkg::OFS_STATUS: begin
          RDATA <= {8'h00, cmd_complete_flag, 1'b0, access_error_flag,
                    protection_violation_flag, 2'h0, verify_error_status,
                    verify_uncorrectable_status};
        end
        fsu_pkg::OFS_INDEX: RDATA <= {13'h0000, param_index_ptr};
        fsu_pkg::OFS_PARAM: begin
          RDATA <= (param_index_ptr < 3'(fsu_pkg::NUM_PARAMS))
                   ? cmd_param_words[param_index_ptr] : 16'h0000;
        end
        fsu_pkg::OFS_SECURITY: begin
          RDATA <= {8'h00, key_enable_field, 3'h0, lockout, security_state_field};
        end
        fsu_pkg::OFS_MARGIN: RDATA <= {MARGIN_BLOCK, MARGIN_LEVEL[13:0]};
        default: RDATA <= 16'h0000;
      endcase
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Cycles since an accepted key launch, kept apart from the run counter
  always_ff @(posedge CLK) begin
    if (RST || finish) begin
      key_age <= 17'h00000;
    end else if (launch && !early_err && code == fsu_pkg::CMD_VERIFY_KEY) begin
      key_age <= 17'h00001;
    end else if (key_age != 17'h00000) begin
      key_age <= key_age + 17'h00001;
    end
  end

  sequence key_launch_s;
    launch && code == fsu_pkg::CMD_VERIFY_KEY;
  endsequence
  sequence key_end_s;
    finish && run_cmd == fsu_pkg::CMD_VERIFY_KEY;
  endsequence

  key_run_a: assert property (key_launch_s ##0 !early_err |=>
    state == FSU_BUSY && run_cmd == fsu_pkg::CMD_VERIFY_KEY)
    else $error("key command did not start");
  key_time_a: assert property (key_age != 17'h00000 |->
    key_age <= fsu_pkg::KEY_CYCLES && finish == (key_age == fsu_pkg::KEY_CYCLES))
    else $error("key command did not run its full time");
  key_enable_field_check_a: assert property (key_launch_s ##0 key_enable_field != 2'h2 |=>
    access_error_flag && cmd_complete_flag && state == FSU_IDLE)
    else $error("disabled key access not refused");
  index_check_a: assert property (key_launch_s ##0 param_index_ptr != 3'h4 |=>
    access_error_flag) else $error("bad index not flagged");
  unlock_a: assert property (key_end_s ##0 all_match |=>
    security_state_field == 2'h2 && !SECURED) else $error("match did not unlock");
  mismatch_a: assert property (key_end_s ##0 !all_match |=>
    lockout && access_error_flag && $stable(security_state_field))
    else $error("mismatch not locked out");
  lock_hold_a: assert property (lockout |=> lockout)
    else $error("lockout lost without reset");
  locked_refuse_a: assert property (key_launch_s ##0 lockout |=>
    access_error_flag && state == FSU_IDLE) else $error("locked key command ran");
  key_complete_a: assert property (key_end_s |=> cmd_complete_flag)
    else $error("complete flag missing after key command");
  erase_unsec_a: assert property (finish && run_cmd == fsu_pkg::CMD_ERASE_VERIFY_ALL
    && blank == 2'h3 |=> !SECURED && DEBUG_ALL_EN) else $error("blank verify did not unsecure");
  debug_en_a: assert property (DEBUG_ALL_EN != SECURED
    && (!$rose(DEBUG_ALL_EN) || $past(finish))) else $error("debug enable without unlock");
  margin_set_a: assert property (finish && run_cmd == fsu_pkg::CMD_USER_MARGIN |=>
    MARGIN_LEVEL == $past(cmd_param_words[1])) else $error("margin not taken");
endmodule

// ==== tb/fsu_host_model.sv ====
/*
  Host model for the flash security unlock block: the software or debug
  host that writes the command registers over the plain register port.
  Assumes one bus clock, read data one cycle after the read strobe, and
  that the bench calls these tasks one at a time.
*/
`timescale 1ns/1ps
module fsu_host_model (
  // Clock
  input wire logic clk,
  // Register port
  input wire logic [15:0] rdata,
  output logic [2:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  // ****************************************************
  // Bus cycles
  // ****************************************************
  // Idle bus with strobes low
  initial begin
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One-cycle write; released lines go to the inverse so a missed strobe shows
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  // One-cycle read; data taken in the cycle after the strobe only
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask

  // ****************************************************
  // Command sequences
  // ****************************************************
  // Pointer first, then the parameter word at it
  task automatic load(input logic [2:0] idx, input logic [15:0] w);
    wr_reg(fsu_pkg::OFS_INDEX, {13'h0000, idx});
    wr_reg(fsu_pkg::OFS_PARAM, w);
  endtask

  // Key command word, then keys at indices 1 up to last
  task automatic send_key(input logic [15:0] k [4], input int last);
    load(3'h0, {fsu_pkg::CMD_VERIFY_KEY, 8'h00});
    for (int i = 1; i <= last; i++) begin
      load(3'(i), k[i-1]);
    end
  endtask

  // Launch from bench code, which never lives in the block holding the keys
  task automatic launch;
    wr_reg(fsu_pkg::OFS_STATUS, 16'h0080);
  endtask

  // Poll status until the complete flag is back, bounded
  task automatic wait_done(output int n, output logic [15:0] st);
    n = 0;
    st = 16'h0000;
    while (st[fsu_pkg::BIT_CMD_COMPLETE_FLAG] !== 1'b1 && n < 600) begin
      rd_reg(fsu_pkg::OFS_STATUS, st);
      n++;
    end
  endtask
endmodule

// ==== tb/fsu_testbench.sv ====
/*
  Self-checking bench for the flash security unlock block.
  Assumes the host model drives the register port; this module holds the
  stored configuration field and the array blank results.
*/
`timescale 1ns/1ps
module testbench;
  // Short erase verify keeps the run brief
  localparam int EV = 20;
  localparam int LIMIT = 20000;
  localparam int KC = int'(fsu_pkg::KEY_CYCLES);
  localparam int MC = int'(fsu_pkg::MARGIN_CYCLES);
  logic clk, rst, wr, rd, pf_blank, dm_blank, secured, dbg_en;
  logic [2:0] addr;
  logic [15:0] wdata, rdata, m_level;
  logic [7:0] sec_byte;
  logic [1:0] m_block;
  logic [15:0] key_word [4];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;

  fsu_top #(.ERASE_VERIFY_CYCLES(EV)) dut_u (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .STORED_SEC_BYTE(sec_byte), .KEY_WORD0(key_word[0]), .KEY_WORD1(key_word[1]),
    .KEY_WORD2(key_word[2]), .KEY_WORD3(key_word[3]), .PFLASH_BLANK(pf_blank),
    .DMEM_BLANK(dm_blank), .SECURED(secured), .DEBUG_ALL_EN(dbg_en),
    .MARGIN_BLOCK(m_block), .MARGIN_LEVEL(m_level)
  );
  fsu_host_model host_u (
    .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
  );

  // ****************************************************
  // Clock, timeout and verdict
  // ****************************************************
  // Free-running bus clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************
  // Compare helpers
  // ****************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_span(input string what, input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      fails++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Reset with a given stored byte; config is sampled just after release
  task automatic do_reset(input logic [7:0] sb);
    @(posedge clk);
    sec_byte <= sb;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("reset debug enable", 16'h0001, {15'h0000, dbg_en});
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Launch, wait, judge run time and status, then clear error flags
  task automatic run(input logic [15:0] st_exp, input int lo, input int hi);
    int t0;
    int n;
    logic [15:0] st;
    host_u.launch();
    t0 = cyc;
    host_u.wait_done(n, st);
    chk_span("run time", cyc - t0, lo, hi);
    chk("status", st_exp, st);
    host_u.wr_reg(fsu_pkg::OFS_STATUS, 16'h0030);
  endtask

  // Security register and both pins against the expected state field
  task automatic chk_sec(input logic [15:0] sr_exp);
    logic [15:0] sr;
    host_u.rd_reg(fsu_pkg::OFS_SECURITY, sr);
    chk("security reg", sr_exp, sr);
    chk("secured pin", {15'h0000, sr_exp[1:0] != 2'h2}, {15'h0000, secured});
    chk("debug enable", {15'h0000, sr_exp[1:0] == 2'h2}, {15'h0000, dbg_en});
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  // Idle after reset: secured, flag set, unmapped offset reads zero
  task automatic t_idle;
    logic [15:0] v;
    do_reset(8'h80);
    chk_sec(16'h0080);
    host_u.rd_reg(fsu_pkg::OFS_STATUS, v);
    chk("idle status", 16'h0080, v);
    host_u.rd_reg(3'h7, v);
    chk("unmapped read", 16'h0000, v);
  endtask

  // Every disabled key-enable code refuses at once
  task automatic t_key_enable_field;
    for (int e = 0; e < 4; e++) begin
      if (e != 2) begin
        do_reset({2'(e), 6'h00});
        host_u.send_key(key_word, 4);
        run(16'h00A0, 0, 6);
        chk_sec({8'h00, 2'(e), 6'h00});
      end
    end
  endtask

  // Short key load refused, then a full correct load releases security
  task automatic t_good;
    do_reset(8'h80);
    host_u.send_key(key_word, 3);
    run(16'h00A0, 0, 6);
    chk_sec(16'h0080);
    host_u.send_key(key_word, 4);
    run(16'h0080, KC - 1, KC + 6);
    chk_sec(16'h0082);
  endtask

  // A bad word in any position locks out until the next reset
  task automatic t_lockout;
    logic [15:0] bad [4];
    for (int w = 0; w < 4; w++) begin
      do_reset(8'h80);
      bad = key_word;
      bad[w] = bad[w] ^ 16'h8001;
      host_u.send_key(bad, 4);
      run(16'h00A0, KC - 1, KC + 6);
      chk_sec(16'h0084);
      host_u.send_key(key_word, 4);
      run(16'h00A0, 0, 6);
      chk_sec(16'h0084);
    end
    do_reset(8'h80);
    host_u.send_key(key_word, 4);
    run(16'h0080, KC - 1, KC + 6);
    chk_sec(16'h0082);
  endtask

  // Every block code with its own level, then a short load refused
  task automatic t_margin;
    logic [15:0] lv;
    logic [15:0] v;
    for (int b = 0; b < 4; b++) begin
      lv = 16'h1234 + 16'(b * 257);
      host_u.load(3'h0, {fsu_pkg::CMD_USER_MARGIN, 6'h00, 2'(b)});
      host_u.load(3'h1, lv);
      run(16'h0080, MC - 1, MC + 6);
      chk("margin block", 16'(b), {14'h0000, m_block});
      chk("margin level", lv, m_level);
      host_u.rd_reg(fsu_pkg::OFS_MARGIN, v);
      chk("margin reg", {2'(b), lv[13:0]}, v);
    end
    host_u.load(3'h0, {fsu_pkg::CMD_USER_MARGIN, 8'h01});
    run(16'h00A0, 0, 6);
    host_u.load(3'h0, 16'h3F00);
    run(16'h00A0, 0, 6);
  endtask

  // Host unsecure path: only both memories blank unsecures
  task automatic t_erase;
    for (int c = 1; c < 4; c++) begin
      do_reset(8'h80);
      pf_blank <= c[0];
      dm_blank <= c[1];
      repeat (8) @(posedge clk);
      host_u.load(3'h0, {fsu_pkg::CMD_ERASE_VERIFY_ALL, 8'h00});
      run((c == 3) ? 16'h0080 : 16'h0082, EV - 1, EV + 8);
      chk_sec((c == 3) ? 16'h0082 : 16'h0080);
    end
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    sec_byte = 8'h80;
    pf_blank = 1'b0;
    dm_blank = 1'b0;
    key_word = '{16'hA5C3, 16'h0F1E, 16'h7788, 16'hFFFF};
    t_idle();
    t_key_enable_field();
    t_good();
    t_lockout();
    t_margin();
    t_erase();
    print_verdict();
  end
endmodule
